//--- hw/config_status_register.sv
// Configuration and status register with shutdown and software reset registers behind an APB slave
`timescale 1ns/1ns
module config_status_register
    import csr_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic hw_reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [DATA_W/8-1:0] pstrb_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [DATA_W-1:0] prdata_o,
    output logic reference_selector_o,
    output logic ramp_control_out_o,
    output logic cooler_ramp_unit_en_o,
    output logic path_switch_off_o,
    output logic aux_switch_off_o,
    output logic irq_o
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Address decode, shared by the read and write paths
    function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
        reg_sel_type sel;
        sel = SEL_NONE;
        if (addr == ADDR_SHUTDOWN) begin
            sel = SEL_SHUTDOWN;
        end else if (addr == ADDR_SW_RESET) begin
            sel = SEL_SW_RESET;
        end else if (addr == ADDR_CONFIG) begin
            sel = SEL_CONFIG;
        end else if (addr == ADDR_IRQ_STATUS) begin
            sel = SEL_IRQ_STATUS;
        end else if (addr == ADDR_IRQ_MASK) begin
            sel = SEL_IRQ_MASK;
        end
        return sel;
    endfunction

    // Two-bit field that accepts only 01 and 10
    function automatic logic [1:0] keep_valid(input logic [1:0] old, input logic [1:0] code);
        logic [1:0] res;
        res = old;
        if (code == CODE_LOW_VALID || code == CODE_HIGH_VALID) begin
            res = code;
        end
        return res;
    endfunction

    // Flags a two-bit code that the field refuses
    function automatic logic is_invalid(input logic [1:0] code);
        return code != CODE_LOW_VALID && code != CODE_HIGH_VALID;
    endfunction

    // ----------------------------------------
    // Bus phase decode
    // ----------------------------------------
    reg_sel_type sel;
    logic access_first;
    logic wr_done;
    logic low_lane;
    logic cfg_wr;
    logic shut_wr;
    logic key_hit;
    logic sw_reset_req;
    logic dev_reset;

    assign sel = decode(paddr_i);
    assign access_first = psel_i & penable_i & ~pready_o;
    assign wr_done = psel_i & penable_i & pready_o & pwrite_i;
    assign low_lane = pstrb_i[0];
    assign cfg_wr = wr_done & low_lane & (sel == SEL_CONFIG);
    assign shut_wr = wr_done & low_lane & (sel == SEL_SHUTDOWN);
    assign key_hit = (pwdata_i[KEY_W-1:0] == SW_RESET_KEY) & pstrb_i[0] & pstrb_i[1];

    // Ready after one wait state; the write lands on the ready edge
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= access_first;
        end
    end

    // Software reset request, one cycle after a key write
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sw_reset_req <= 1'b0;
        end else begin
            sw_reset_req <= wr_done & (sel == SEL_SW_RESET) & key_hit;
        end
    end

    // Device reset from the pin or from software
    assign dev_reset = ~hw_reset_n_i | sw_reset_req;

    // ----------------------------------------
    // Configuration and status fields
    // ----------------------------------------
    logic reset_done_flag;
    logic [1:0] sign_mode;
    logic [1:0] cooler_ramp_select;
    logic [1:0] wr_pol;
    logic [1:0] wr_ramp;

    assign wr_pol = pwdata_i[POL_LSB +: FIELD_W];
    assign wr_ramp = pwdata_i[RAMP_LSB +: FIELD_W];

    // Reset-occurred flag: set by resets only, cleared by a written zero
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reset_done_flag <= FLAG_RESET; // R2
        end else if (dev_reset) begin
            reset_done_flag <= FLAG_RESET; // R2
        end else if (cfg_wr && !pwdata_i[FLAG_BIT]) begin
            reset_done_flag <= 1'b0; // R3
        end
    end

    // Polarity field, refusing 00 and 11
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sign_mode <= POL_BIPOLAR; // R6
        end else if (dev_reset) begin
            sign_mode <= POL_BIPOLAR; // R6
        end else if (cfg_wr) begin
            sign_mode <= keep_valid(sign_mode, wr_pol); // R5
        end
    end

    // Soft-start field, refusing 11 only
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cooler_ramp_select <= RAMP_ON; // R10
        end else if (dev_reset) begin
            cooler_ramp_select <= RAMP_ON; // R10
        end else if (cfg_wr && wr_ramp != RAMP_INVALID) begin
            cooler_ramp_select <= wr_ramp; // R9
        end
    end

    // ----------------------------------------
    // Shutdown register, both switches disabled after reset
    // ----------------------------------------
    logic [1:0] sw1_ctl;
    logic [1:0] sw2_ctl;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sw1_ctl <= SW_DISABLED;
            sw2_ctl <= SW_DISABLED;
        end else if (dev_reset) begin
            sw1_ctl <= SW_DISABLED;
            sw2_ctl <= SW_DISABLED;
        end else if (shut_wr) begin
            sw1_ctl <= keep_valid(sw1_ctl, pwdata_i[SW1_LSB +: FIELD_W]);
            sw2_ctl <= keep_valid(sw2_ctl, pwdata_i[SW2_LSB +: FIELD_W]);
        end
    end

    // ----------------------------------------
    // Control outputs, registered from the stored fields
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reference_selector_o <= 1'b1;
            ramp_control_out_o <= 1'b1;
            cooler_ramp_unit_en_o <= 1'b1;
            path_switch_off_o <= 1'b1;
            aux_switch_off_o <= 1'b1;
        end else begin
            reference_selector_o <= (sign_mode == POL_BIPOLAR); // R4
            ramp_control_out_o <= (cooler_ramp_select == RAMP_ON); // R7 R8
            cooler_ramp_unit_en_o <= (cooler_ramp_select == RAMP_ON) && (sw2_ctl == SW_DISABLED); // R8
            path_switch_off_o <= (sw2_ctl == SW_DISABLED); // R11
            aux_switch_off_o <= (sw1_ctl == SW_DISABLED);
        end
    end

    // ----------------------------------------
    // Interrupt events and registers
    // ----------------------------------------
    logic [N_EVENTS-1:0] events;
    logic [N_EVENTS-1:0] irq_status;
    logic [N_EVENTS-1:0] irq_mask;
    logic bad_cfg;
    logic bad_shut;

    assign bad_cfg = cfg_wr & (is_invalid(wr_pol) | (wr_ramp == RAMP_INVALID));
    assign bad_shut = shut_wr & (is_invalid(pwdata_i[SW1_LSB +: FIELD_W]) | is_invalid(pwdata_i[SW2_LSB +: FIELD_W]));
    assign events[EV_RESET] = dev_reset;
    assign events[EV_BAD_WRITE] = (bad_cfg | bad_shut) & ~dev_reset;

    event_irq #(
        .N(N_EVENTS)
    ) u_irq (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .event_i(events),
        .clear_wr_i(wr_done & low_lane & (sel == SEL_IRQ_STATUS)),
        .mask_wr_i(wr_done & low_lane & (sel == SEL_IRQ_MASK)),
        .wdata_i(pwdata_i[N_EVENTS-1:0]),
        .status_o(irq_status),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );

    // ----------------------------------------
    // Read data and error answer
    // ----------------------------------------
    logic [DATA_W-1:0] read_word;

    // Read mux; unused bits stay zero
    always_comb begin
        read_word = '0;
        case (sel)
            SEL_SHUTDOWN: begin
                read_word[SW1_LSB +: FIELD_W] = sw1_ctl;
                read_word[SW2_LSB +: FIELD_W] = sw2_ctl;
            end
            SEL_CONFIG: begin
                read_word[FLAG_BIT] = reset_done_flag; // R1 R12
                read_word[POL_LSB +: FIELD_W] = sign_mode; // R1
                read_word[RAMP_LSB +: FIELD_W] = cooler_ramp_select; // R1
            end
            SEL_IRQ_STATUS: begin
                read_word[N_EVENTS-1:0] = irq_status;
            end
            SEL_IRQ_MASK: begin
                read_word[N_EVENTS-1:0] = irq_mask;
            end
            default: begin
                read_word = '0;
            end
        endcase
    end

    // Read data and error, valid together with ready
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end else if (access_first) begin
            prdata_o <= pwrite_i ? '0 : read_word;
            pslverr_o <= (sel == SEL_NONE);
        end else begin
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_access_wait;
        psel_i && penable_i && !pready_o;
    endsequence

    sequence s_access_done;
        pready_o ##1 !pready_o;
    endsequence

    a_bus_ready_wait: assert property (s_access_wait |=> s_access_done)
        else $error("ready not given after one wait state");

    a_flag_reset_set: assert property (dev_reset |=> reset_done_flag) // R2
        else $error("reset did not set the flag");

    a_flag_write_clear: assert property (cfg_wr && !pwdata_i[FLAG_BIT] && !dev_reset |=> !reset_done_flag) // R3
        else $error("written zero did not clear the flag");

    a_flag_only_reset: assert property ($rose(reset_done_flag) |-> $past(dev_reset)) // R3
        else $error("flag set without a reset");

    a_pol_ignore_bad: assert property (cfg_wr && is_invalid(wr_pol) && !dev_reset |=> $stable(sign_mode)) // R5
        else $error("invalid polarity code was stored");

    a_pol_after_reset: assert property (dev_reset |=> sign_mode == POL_BIPOLAR ##1 reference_selector_o) // R6 R4
        else $error("polarity not bipolar after reset");

    a_ref_follows_pol: assert property (reference_selector_o == ($past(sign_mode) == POL_BIPOLAR)) // R4
        else $error("reference selector does not follow polarity");

    a_ramp_ignore_bad: assert property (cfg_wr && wr_ramp == RAMP_INVALID && !dev_reset // R9
        |=> $stable(cooler_ramp_select) ##1 $stable(ramp_control_out_o))
        else $error("soft-start code 11 was not ignored");

    a_ramp_out_level: assert property (ramp_control_out_o == ($past(cooler_ramp_select) == RAMP_ON)) // R7 R8
        else $error("ramp control output wrong for stored code");

    a_cooler_gate: assert property (cooler_ramp_unit_en_o |-> $past(cooler_ramp_select == RAMP_ON) // R8
        && $past(sw2_ctl == SW_DISABLED))
        else $error("ramp unit enabled against the gating");

    a_ramp_after_reset: assert property (dev_reset |=> cooler_ramp_select == RAMP_ON ##1 ramp_control_out_o) // R10
        else $error("soft-start not 01 after reset");

    a_switch_off_level: assert property (path_switch_off_o == ($past(sw2_ctl) == SW_DISABLED)) // R11
        else $error("path switch off signal wrong");

    a_reserved_zero: assert property (access_first && !pwrite_i && sel == SEL_CONFIG // R12 R1
        |=> prdata_o[REG_W-1:USED_W] == '0 && prdata_o[FLAG_BIT] == $past(reset_done_flag))
        else $error("config read shows wrong bits");

endmodule

//--- hw/event_irq.sv
// Sticky event status, write-one-to-clear, mask and level interrupt output
`timescale 1ns/1ns
module event_irq #(
    parameter int N = 2
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [N-1:0] event_i,
    input wire logic clear_wr_i,
    input wire logic mask_wr_i,
    input wire logic [N-1:0] wdata_i,
    output logic [N-1:0] status_o,
    output logic [N-1:0] mask_o,
    output logic irq_o
);

    logic [N-1:0] next_status;

    // --------------------------------------------------
    // Status bits: an event in the clearing cycle wins
    // --------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            assign next_status[g] = event_i[g] | (status_o[g] & ~(clear_wr_i & wdata_i[g]));
        end
    endgenerate

    // Status register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_o <= '0;
        end else begin
            status_o <= next_status;
        end
    end

    // Mask register, all events masked after reset
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_o <= '0;
        end else if (mask_wr_i) begin
            mask_o <= wdata_i;
        end
    end

    // Level interrupt, high while an enabled status bit is set
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_o & mask_o);
        end
    end

endmodule

//--- pkg/csr_pkg.sv
// Constants, field layout and codes of the configuration and status register block
//
// Function
// [R1] The register is 16 bits: flag at bit 4, polarity at bits 3:2, soft-start at bits 1:0, bits 15:5 unused.
// [R2] Power-up, the hardware reset pin and a software reset all set the reset-occurred flag.
// [R3] Writing zero to the flag clears it, writing one leaves it, since only a reset may set it.
// [R4] Polarity 01 selects bipolar (reference at 2.5V), 10 selects unipolar (reference at analog ground).
// [R5] A written polarity of 00 or 11 is ignored and the stored polarity stays.
// [R6] After any reset the polarity holds the bipolar code.
// [R7] Soft-start 00 or 10 drives the ramp control output low and disables the cooler ramp unit.
// [R8] Soft-start 01 drives the ramp control output high; the ramp unit runs only while the path switch is off.
// [R9] A written soft-start of 11 is ignored and the field and the ramp control output stay.
// [R10] After any reset the soft-start field reads 01 and the ramp control output is high.
// [R11] The path-switch-off signal is high while the output path switch is disabled, low while enabled.
// [R12] Bits 15:5 ignore writes and read as zero.
package csr_pkg;

    // ----------------------------------------
    // Bus and register geometry
    // ----------------------------------------
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int ADDR_W = 12;
    localparam int ADDR_STRIDE = 4;

    // Register indices and byte addresses
    localparam logic [4:0] IDX_SHUTDOWN = 5'h00;
    localparam logic [4:0] IDX_SW_RESET = 5'h01;
    localparam logic [4:0] IDX_CONFIG = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_SHUTDOWN = ADDR_W'(IDX_SHUTDOWN * ADDR_STRIDE);
    localparam logic [ADDR_W-1:0] ADDR_SW_RESET = ADDR_W'(IDX_SW_RESET * ADDR_STRIDE);
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = ADDR_W'(IDX_CONFIG * ADDR_STRIDE);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h040;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h044;

    // Decoded register selection
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_SHUTDOWN = 3'b001,
        SEL_SW_RESET = 3'b010,
        SEL_CONFIG = 3'b011,
        SEL_IRQ_STATUS = 3'b100,
        SEL_IRQ_MASK = 3'b101
    } reg_sel_type;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FLAG_BIT = 4;
    localparam int POL_LSB = 2;
    localparam int RAMP_LSB = 0;
    localparam int SW2_LSB = 0;
    localparam int SW1_LSB = 2;
    localparam int FIELD_W = 2;
    localparam int USED_W = 5;
    localparam int SHUT_USED_W = 4;
    localparam int KEY_W = 12;

    // ----------------------------------------
    // Field codes and reset values
    // ----------------------------------------
    localparam logic [1:0] CODE_LOW_VALID = 2'h1;
    localparam logic [1:0] CODE_HIGH_VALID = 2'h2;
    localparam logic [1:0] POL_BIPOLAR = 2'h1;
    localparam logic [1:0] POL_UNIPOLAR = 2'h2;
    localparam logic [1:0] RAMP_ON = 2'h1;
    localparam logic [1:0] RAMP_INVALID = 2'h3;
    localparam logic [1:0] SW_ENABLED = 2'h1;
    localparam logic [1:0] SW_DISABLED = 2'h2;
    localparam logic FLAG_RESET = 1'h1;
    localparam logic [KEY_W-1:0] SW_RESET_KEY = 12'hBB3;

    // ----------------------------------------
    // Interrupt events
    // ----------------------------------------
    localparam int N_EVENTS = 2;
    localparam int EV_RESET = 0;
    localparam int EV_BAD_WRITE = 1;

endpackage

//--- test/config_status_register_test.sv
// Self-checking testbench of the configuration and status register block
`timescale 1ns/1ns
module config_status_register_test
    import csr_pkg::*;
;
    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    logic clock_i;
    logic arst_n_i;
    logic hw_reset_n_i;
    logic psel_i;
    logic penable_i;
    logic pwrite_i;
    logic [ADDR_W-1:0] paddr_i;
    logic [DATA_W-1:0] pwdata_i;
    logic [DATA_W/8-1:0] pstrb_i;
    logic pready_o;
    logic pslverr_o;
    logic [DATA_W-1:0] prdata_o;
    logic reference_selector_o;
    logic ramp_control_out_o;
    logic cooler_ramp_unit_en_o;
    logic path_switch_off_o;
    logic aux_switch_off_o;
    logic irq_o;
    typedef struct {logic rd; logic [DATA_W-1:0] data; logic err;} expect_type;
    expect_type exp_q[$];
    int fail_count = 0;
    int cmp_count = 0;
    integer seed = 96890;
    logic flag;
    logic [1:0] pol;
    logic [1:0] ramp;
    logic [DATA_W-1:0] v;

    config_status_register dut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .hw_reset_n_i(hw_reset_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .prdata_o(prdata_o), .reference_selector_o(reference_selector_o),
        .ramp_control_out_o(ramp_control_out_o), .cooler_ramp_unit_en_o(cooler_ramp_unit_en_o),
        .path_switch_off_o(path_switch_off_o), .aux_switch_off_o(aux_switch_off_o), .irq_o(irq_o)
    );

    // Clock at 50 MHz
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic mismatch(input string msg);
        fail_count++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatch($sformatf("%s got %h expected %h", what, got, exp));
        end
    endtask

    // One APB transfer; the expected answer is queued for the monitor
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
                       input logic [3:0] strb, input logic [DATA_W-1:0] rexp, input logic eexp);
        expect_type e;
        e.rd = !wr;
        e.data = rexp;
        e.err = eexp;
        exp_q.push_back(e);
        @(posedge clock_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= data;
        pstrb_i <= strb;
        @(posedge clock_i);
        penable_i <= 1'b1;
        // Wait for ready however long it takes; only the watchdog ends a hang
        do begin
            @(posedge clock_i);
        end while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        apb(1'b1, addr, data, 4'hF, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp, input logic err = 1'b0);
        apb(1'b0, addr, 32'h0, 4'hF, exp, err);
    endtask

    // Let the control outputs follow the stored fields
    task automatic settle();
        repeat (2) @(posedge clock_i);
        #1;
    endtask

    // Reference, ramp, ramp unit, path switch off, aux switch off
    task automatic outs(input logic [4:0] exp);
        chk({reference_selector_o, ramp_control_out_o, cooler_ramp_unit_en_o, path_switch_off_o,
             aux_switch_off_o}, exp, "control outputs");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Response monitor
    // ----------------------------------------
    always @(posedge clock_i) begin
        expect_type e;
        if (arst_n_i === 1'b1 && pready_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatch("response with nothing pending");
            end else begin
                e = exp_q.pop_front();
                cmp_count++;
                if (pslverr_o !== e.err || (e.rd && prdata_o !== e.data)) begin
                    mismatch($sformatf("read %h err %b expected %h err %b", prdata_o, pslverr_o, e.data, e.err));
                end
            end
        end
    end

    // Watchdog against a hang
    initial begin
        #500000;
        mismatch("watchdog expired");
        end_of_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        arst_n_i = 1'b0;
        hw_reset_n_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = '0;
        pwdata_i = '0;
        pstrb_i = '0;
        repeat (6) @(posedge clock_i);
        arst_n_i <= 1'b1;
        #1;
        outs(5'h1F);
        rd(ADDR_CONFIG, 32'h15);
        rd(ADDR_SHUTDOWN, 32'hA);
        rd(12'h00C, 32'h0, 1'b1);
        wr(ADDR_CONFIG, 32'hFFFFFFFF);
        rd(ADDR_CONFIG, 32'h15);
        flag = 1'b1;
        pol = POL_BIPOLAR;
        ramp = RAMP_ON;
        // Every code pair twice, with random flag and unused bits
        for (int i = 0; i < 32; i++) begin
            v = $random(seed);
            v[3:0] = i[3:0];
            wr(ADDR_CONFIG, v);
            if (!v[4]) flag = 1'b0;
            if (v[3:2] == POL_BIPOLAR || v[3:2] == POL_UNIPOLAR) pol = v[3:2];
            if (v[1:0] != RAMP_INVALID) ramp = v[1:0];
            settle();
            rd(ADDR_CONFIG, {27'h0, flag, pol, ramp});
            outs({pol == POL_BIPOLAR, ramp == RAMP_ON, ramp == RAMP_ON, 2'b11});
        end
        // Ramp unit gated by the output path switch
        wr(ADDR_CONFIG, 32'h5);
        wr(ADDR_SHUTDOWN, 32'h5);
        settle();
        outs(5'h18);
        wr(ADDR_SHUTDOWN, 32'h6);
        settle();
        outs(5'h1E);
        // Refused switch codes leave the shutdown fields as they were
        wr(ADDR_SHUTDOWN, 32'hC);
        rd(ADDR_SHUTDOWN, 32'h6);
        settle();
        outs(5'h1E);
        // Rejected codes raised an event; unmask, then clear
        rd(ADDR_IRQ_STATUS, 32'h2);
        wr(ADDR_IRQ_MASK, 32'h3);
        settle();
        chk(irq_o, 1'b1, "irq after unmask");
        wr(ADDR_IRQ_STATUS, 32'h2);
        settle();
        chk(irq_o, 1'b0, "irq after clear");
        rd(ADDR_IRQ_STATUS, 32'h0);
        // Hardware reset pin
        @(posedge clock_i);
        hw_reset_n_i <= 1'b0;
        @(posedge clock_i);
        hw_reset_n_i <= 1'b1;
        settle();
        rd(ADDR_CONFIG, 32'h15);
        rd(ADDR_SHUTDOWN, 32'hA);
        outs(5'h1F);
        chk(irq_o, 1'b1, "irq after pin reset");
        rd(ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h0);
        settle();
        chk(irq_o, 1'b0, "irq while masked");
        wr(ADDR_IRQ_STATUS, 32'h1);
        // Software reset, wrong key first
        wr(ADDR_CONFIG, 32'hA);
        settle();
        outs(5'h03);
        wr(ADDR_SW_RESET, 32'hBB2);
        settle();
        rd(ADDR_CONFIG, 32'hA);
        apb(1'b1, ADDR_SW_RESET, 32'hFBB3, 4'h3, 32'h0, 1'b0);
        settle();
        rd(ADDR_CONFIG, 32'h15);
        rd(ADDR_SW_RESET, 32'h0);
        outs(5'h1F);
        // Write without the low byte strobe changes nothing
        apb(1'b1, ADDR_CONFIG, 32'hA, 4'hE, 32'h0, 1'b0);
        rd(ADDR_CONFIG, 32'h15);
        settle();
        end_of_test();
    end
endmodule
